// *** design/dcad_decode.sv ***
// Command, address and write-mask input decode of a DDR3 DRAM
`timescale 1ns/1ps
`default_nettype none
`include "dcad_defs.svh"
module dcad_decode (
  // Clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rst,
  // Pins from the memory controller
  input  wire logic                            ck,
  input  wire logic                            cke,
  input  wire logic                            odt,
  input  wire dcad_pkg::dcad_pins_t            pins,
  input  wire dcad_pkg::dcad_data_t            dpins,
  // Device state
  input  wire logic                            power_down,
  input  wire logic                            self_refresh,
  input  wire logic                            wr_active,
  // Decoded command
  output logic                                 cmd_valid,
  output dcad_pkg::dcad_cmd_t                  cmd,
  output logic [`DCAD_MR_N-1:0][`DCAD_MR_W-1:0] mode_reg,
  output logic                                 tdqs_mode,
  // Write data beats
  output logic                                 wr_valid,
  output logic                                 wr_dropped,
  output logic [`DCAD_DQ_W-1:0]                wr_data,
  // Receivers that stay awake
  output logic                                 cke_rx,
  output logic                                 odt_rx
);

  // Maps the four-signal command code to an operation
  function automatic dcad_pkg::dcad_op_t op_of(input dcad_pkg::dcad_pins_t p);
    dcad_pkg::dcad_op_t o;
    o = dcad_pkg::op_nop;
    if (!p.cs_n) begin // R1 R2
      unique case ({p.ras_n, p.cas_n, p.we_n})
        `DCAD_CODE_MRS: o = dcad_pkg::op_mrs;
        `DCAD_CODE_REF: o = dcad_pkg::op_ref;
        `DCAD_CODE_PRE: o = dcad_pkg::op_pre;
        `DCAD_CODE_ACT: o = dcad_pkg::op_act;
        `DCAD_CODE_WR:  o = dcad_pkg::op_wr;
        `DCAD_CODE_RD:  o = dcad_pkg::op_rd;
        `DCAD_CODE_ZQ:  o = dcad_pkg::op_zq;
        default:        o = dcad_pkg::op_nop;
      endcase
    end
    return o;
  endfunction

  // Two-stage synchronisers on every pin; first stage feeds only the second
  dcad_pkg::dcad_pins_t pins_s1, pins_s2;
  dcad_pkg::dcad_data_t data_s1, data_s2;
  logic                 ck_s1, ck_s2, ck_d, dqs_d;
  logic                 cke_s1, cke_s2, odt_s1, odt_s2;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pins_s1 <= '1;
      pins_s2 <= '1;
      data_s1 <= '0;
      data_s2 <= '0;
      {ck_s1, ck_s2, ck_d, dqs_d}     <= 4'h0;
      {cke_s1, cke_s2, odt_s1, odt_s2} <= 4'h0;
    end else begin
      pins_s1 <= pins;
      pins_s2 <= pins_s1;
      data_s1 <= dpins;
      data_s2 <= data_s1;
      ck_s1   <= ck;
      ck_s2   <= ck_s1;
      ck_d    <= ck_s2;
      dqs_d   <= data_s2.dqs;
      cke_s1  <= cke;
      cke_s2  <= cke_s1;
      odt_s1  <= odt;
      odt_s2  <= odt_s1;
    end
  end

  // Receiver gating: self-refresh leaves only CKE, power-down also CK and ODT
  logic ck_rx_en, cmd_rx_en, ck_rise, dqs_edge;
  assign ck_rx_en  = !self_refresh; // R13
  assign cmd_rx_en = !self_refresh && !power_down; // R12
  assign ck_rise   = ck_rx_en && ck_s2 && !ck_d; // R15
  // Both strobe edges carry a beat, so any change counts
  assign dqs_edge  = cmd_rx_en && wr_active && (data_s2.dqs != dqs_d); // R4

  // Next values of the decode, mode registers and write beat
  logic                                  next_cmd_valid;
  dcad_pkg::dcad_cmd_t                   next_cmd;
  logic [`DCAD_MR_N-1:0][`DCAD_MR_W-1:0] next_mode_reg;
  logic                                  next_wr_valid, next_wr_dropped;
  logic [`DCAD_DQ_W-1:0]                 next_wr_data;
  dcad_pkg::dcad_op_t                    cur_op;
  logic                                  dm_eff;

  assign cur_op = op_of(pins_s2);
  // In TDQS mode the shared pin is a strobe, so it never masks data
  assign dm_eff = data_s2.dm && !tdqs_mode; // R5

  always_comb begin
    next_cmd_valid  = 1'b0;
    next_cmd        = cmd;
    next_mode_reg   = mode_reg;
    next_wr_valid   = 1'b0;
    next_wr_dropped = 1'b0;
    next_wr_data    = wr_data;
    if (ck_rise && cmd_rx_en && cur_op != dcad_pkg::op_nop) begin // R1 R12
      next_cmd_valid     = 1'b1;
      next_cmd.op        = cur_op;
      next_cmd.bank      = pins_s2.ba; // R6
      next_cmd.addr      = pins_s2.addr; // R10
      next_cmd.auto_pre  = 1'b0;
      next_cmd.all_banks = 1'b0;
      if (cur_op == dcad_pkg::op_rd || cur_op == dcad_pkg::op_wr) begin
        next_cmd.auto_pre = pins_s2.addr[`DCAD_AP_BIT]; // R8
      end
      if (cur_op == dcad_pkg::op_pre) begin
        next_cmd.all_banks = pins_s2.addr[`DCAD_AP_BIT]; // R9
      end
      // Upper bank bit must be low for a mode register access
      if (cur_op == dcad_pkg::op_mrs && !pins_s2.ba[`DCAD_MR_TDQS]) begin
        next_mode_reg[pins_s2.ba[`DCAD_MR_TDQS-1:0]] =
          {1'b0, pins_s2.addr}; // R7 R11
      end
    end
    if (dqs_edge) begin
      next_wr_data = data_s2.dq;
      if (dm_eff) begin
        next_wr_dropped = 1'b1; // R3
      end else begin
        next_wr_valid = 1'b1; // R3
      end
    end
  end

  // Register the decode results
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_valid  <= 1'b0;
      cmd        <= '0;
      mode_reg   <= {`DCAD_MR_N{`DCAD_MR_RST}};
      wr_valid   <= 1'b0;
      wr_dropped <= 1'b0;
      wr_data    <= '0;
    end else begin
      cmd_valid  <= next_cmd_valid;
      cmd        <= next_cmd;
      mode_reg   <= next_mode_reg;
      wr_valid   <= next_wr_valid;
      wr_dropped <= next_wr_dropped;
      wr_data    <= next_wr_data;
    end
  end

  // Awake receivers and the mask/strobe pin function
  assign tdqs_mode = mode_reg[`DCAD_MR1_IDX][`DCAD_TDQS_BIT]; // R5
  assign cke_rx    = cke_s2; // R13
  assign odt_rx    = odt_s2 && ck_rx_en; // R12

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_cmd_edge;
    ck_rise && cmd_rx_en && cur_op != dcad_pkg::op_nop;
  endsequence

  property p_cs_mask;
    ck_rise && pins_s2.cs_n |=> !cmd_valid;
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("command taken with cs high"); // R1

  property p_code;
    s_cmd_edge |=> cmd_valid && cmd.op == $past(cur_op);
  endproperty
  a_code: assert property (p_code) else $error("command code wrong"); // R2

  property p_mask;
    dqs_edge |=> (wr_valid != wr_dropped) && (wr_dropped == $past(dm_eff));
  endproperty
  a_mask: assert property (p_mask) else $error("mask not honoured"); // R3

  property p_both_edges;
    $changed(data_s2.dqs) && cmd_rx_en && wr_active |=> wr_valid || wr_dropped;
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("strobe edge lost"); // R4

  property p_tdqs;
    tdqs_mode && dqs_edge |=> !wr_dropped;
  endproperty
  a_tdqs: assert property (p_tdqs) else $error("tdqs mode masked data"); // R5

  property p_bank_addr;
    s_cmd_edge |=> cmd.bank == $past(pins_s2.ba) && cmd.addr == $past(pins_s2.addr);
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("bank or address wrong"); // R6 R10

  property p_mrs;
    s_cmd_edge and (cur_op == dcad_pkg::op_mrs && !pins_s2.ba[`DCAD_MR_TDQS]) |=>
      mode_reg[$past(pins_s2.ba[`DCAD_MR_TDQS-1:0])] == {1'b0, $past(pins_s2.addr)};
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode register not loaded"); // R7 R11

  property p_ap;
    cmd_valid && (cmd.op == dcad_pkg::op_rd || cmd.op == dcad_pkg::op_wr) |->
      cmd.auto_pre == cmd.addr[`DCAD_AP_BIT] && !cmd.all_banks;
  endproperty
  a_ap: assert property (p_ap) else $error("auto-precharge wrong"); // R8

  property p_pre_all;
    cmd_valid && cmd.op == dcad_pkg::op_pre |-> cmd.all_banks == cmd.addr[`DCAD_AP_BIT];
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge scope wrong"); // R9

  property p_gated;
    (power_down || self_refresh) |=> !cmd_valid && !wr_valid && !wr_dropped;
  endproperty
  a_gated: assert property (p_gated) else $error("receiver not gated"); // R12 R13

  property p_sr_odt;
    self_refresh |-> !odt_rx;
  endproperty
  a_sr_odt: assert property (p_sr_odt) else $error("odt awake in self-refresh"); // R13

  property p_rise;
    cmd_valid |-> $past(ck_s2) && !$past(ck_d);
  endproperty
  a_rise: assert property (p_rise) else $error("command off the rising edge"); // R15

endmodule
`default_nettype wire

// *** design/dcad_defs.svh ***
// Constants for the DRAM command and address input decode
// Operation
// R1: Chip select high masks every command
// R2: Command code is CS, RAS, CAS, WE
// R3: Beats with mask high are discarded
// R4: Mask sampled on both strobe edges
// R5: MR1 bit A11 picks mask or TDQS
// R6: Bank inputs pick bank for ACT/RD/WR/PRE
// R7: Bank inputs pick mode register on MRS
// R8: A10 high on RD/WR means auto-precharge
// R9: A10 high on PRE precharges all banks
// R10: Row on ACT, column on RD/WR
// R11: MRS loads address op-code into register
// R12: Power-down keeps only CK, ODT, CKE receivers
// R13: Self-refresh keeps only the CKE receiver
// R14: Controller holds CKE high during accesses
// R15: Inputs registered on rising true clock
`ifndef DCAD_DEFS_SVH
`define DCAD_DEFS_SVH
`define DCAD_ADDR_W      15
`define DCAD_BANK_W      3
`define DCAD_DQ_W        8
`define DCAD_MR_W        16
`define DCAD_MR_N        4
`define DCAD_AP_BIT      10
`define DCAD_TDQS_BIT    11
`define DCAD_MR_TDQS     2
`define DCAD_MR1_IDX     1
`define DCAD_MR_RST      16'h0000
`define DCAD_CODE_MRS    3'h0
`define DCAD_CODE_REF    3'h1
`define DCAD_CODE_PRE    3'h2
`define DCAD_CODE_ACT    3'h3
`define DCAD_CODE_WR     3'h4
`define DCAD_CODE_RD     3'h5
`define DCAD_CODE_ZQ     3'h6
`endif

// *** design/dcad_pkg.sv ***
// Types for the DRAM command and address input decode
`include "dcad_defs.svh"
package dcad_pkg;
  // Decoded operations
  typedef enum logic [2:0] {
    op_nop, op_mrs, op_ref, op_pre, op_act, op_wr, op_rd, op_zq
  } dcad_op_t;

  // Command and address pins as sampled
  typedef struct packed {
    logic                      cs_n;
    logic                      ras_n;
    logic                      cas_n;
    logic                      we_n;
    logic [`DCAD_BANK_W-1:0]   ba;
    logic [`DCAD_ADDR_W-1:0]   addr;
  } dcad_pins_t;

  // Decoded command handed to the array logic
  typedef struct packed {
    dcad_op_t                  op;
    logic [`DCAD_BANK_W-1:0]   bank;
    logic [`DCAD_ADDR_W-1:0]   addr;
    logic                      auto_pre;
    logic                      all_banks;
  } dcad_cmd_t;

  // Data pins as sampled
  typedef struct packed {
    logic                      dqs;
    logic                      dm;
    logic [`DCAD_DQ_W-1:0]     dq;
  } dcad_data_t;
endpackage

// *** sim/dcad_ctrl_model.sv ***
// Memory controller model driving clock, command, address and data pins
`timescale 1ns/1ps
`default_nettype none
module dcad_ctrl_model (
  // Clock
  input  wire logic            mclk,
  // Pins toward the device
  output logic                 ck,
  output logic                 cke,
  output logic                 odt,
  output dcad_pkg::dcad_pins_t pins,
  output dcad_pkg::dcad_data_t dpins
);
  // Idle: clock parked low, rank deselected, strobe quiet
  initial begin
    ck = 1'b0;
    cke = 1'b1;
    odt = 1'b0;
    pins = '1;
    dpins = '0;
  end

  // One command per clock frame: four mclk low, four high, so back-to-back
  // frames give a 400 ns link clock; pins settle three mclk before the rise
  task automatic send_cmd(input logic cs_n, input logic [2:0] code,
                          input logic [2:0] ba, input logic [14:0] a);
    @(posedge mclk);
    pins <= {cs_n, code, ba, a};
    repeat (3) @(posedge mclk);
    ck <= 1'b1;
    repeat (4) @(posedge mclk);
    ck <= 1'b0;
    // Released bus shows inverted junk so a stale sample cannot pass
    pins <= {1'b1, 3'h7, ~ba, ~a};
  endtask

  // One data beat per strobe edge, mask travels with its beat
  task automatic send_beat(input logic dm, input logic [7:0] dq);
    @(posedge mclk);
    dpins <= {~dpins.dqs, dm, dq};
    repeat (4) @(posedge mclk);
    dpins.dm <= ~dm;
    dpins.dq <= ~dq;
    repeat (2) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the command and address input decode
`timescale 1ns/1ps
`default_nettype none
`include "dcad_defs.svh"
module testbench;
  logic                 mclk, rst, power_down, self_refresh, wr_active;
  logic                 ck, cke, odt, cmd_valid, tdqs_mode;
  logic                 wr_valid, wr_dropped, cke_rx, odt_rx;
  dcad_pkg::dcad_pins_t pins;
  dcad_pkg::dcad_data_t dpins;
  dcad_pkg::dcad_cmd_t  cmd;
  logic [`DCAD_MR_N-1:0][`DCAD_MR_W-1:0] mode_reg;
  logic [`DCAD_DQ_W-1:0] wr_data;
  int                   n_mismatch, samples_checked, n_cmd, n_ok, n_drop;

  dcad_ctrl_model ctl (.mclk(mclk), .ck(ck), .cke(cke), .odt(odt), .pins(pins),
    .dpins(dpins));
  dcad_decode dut (.mclk(mclk), .rst(rst), .ck(ck), .cke(cke), .odt(odt), .pins(pins),
    .dpins(dpins), .power_down(power_down), .self_refresh(self_refresh),
    .wr_active(wr_active), .cmd_valid(cmd_valid), .cmd(cmd), .mode_reg(mode_reg),
    .tdqs_mode(tdqs_mode), .wr_valid(wr_valid), .wr_dropped(wr_dropped),
    .wr_data(wr_data), .cke_rx(cke_rx), .odt_rx(odt_rx));

  // 20 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Count pulses on the falling edge, clear of the register updates
  always @(negedge mclk) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (wr_valid === 1'b1) n_ok++;
    if (wr_dropped === 1'b1) n_drop++;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Every register, then a reserved bank that must leave them alone
  task automatic t_mrs();
    for (int r = 0; r < 5; r++) begin
      ctl.send_cmd(1'b0, `DCAD_CODE_MRS, 3'(r), 15'(r * 15'h1111 + 15'h0101));
      if (r < 4) check("mode_reg", 32'(r * 15'h1111 + 15'h0101), 32'(mode_reg[r]));
    end
    check("mode_reg0", 32'h0101, 32'(mode_reg[0]));
    check("tdqs_mode", 32'h0, 32'(tdqs_mode));
  endtask

  // Each code except MRS with the A10 bit low then high
  task automatic t_cmds();
    logic [2:0]  c;
    logic        ap;
    logic [14:0] a;
    int          n0;
    for (int k = 2; k < 14; k++) begin
      c = 3'(k / 2);
      ap = k[0];
      a = {4'h5, ap, 10'(k * 37)};
      n0 = n_cmd;
      ctl.send_cmd(1'b0, c, 3'(k), a);
      check("count", 32'(n0 + 1), 32'(n_cmd));
      check("op", 32'(c + 1), 32'(cmd.op));
      check("addr", 32'(a), 32'(cmd.addr));
      if (!(c == `DCAD_CODE_PRE && ap)) check("bank", 32'(k % 8), 32'(cmd.bank));
      if (c == `DCAD_CODE_WR || c == `DCAD_CODE_RD) check("auto_pre", 32'(ap), 32'(cmd.auto_pre));
      if (c == `DCAD_CODE_PRE) check("all_banks", 32'(ap), 32'(cmd.all_banks));
    end
  endtask

  // Deselected rank and idle code produce nothing; low-power gating
  task automatic t_mask_low();
    int n0;
    n0 = n_cmd;
    ctl.send_cmd(1'b1, `DCAD_CODE_ACT, 3'h1, 15'h0001);
    check("deselected", 32'(n0), 32'(n_cmd));
    ctl.send_cmd(1'b0, 3'h7, 3'h1, 15'h0001);
    check("nop", 32'(n0), 32'(n_cmd));
    power_down <= 1'b1;
    ctl.odt <= 1'b1;
    ctl.send_cmd(1'b0, `DCAD_CODE_ACT, 3'h2, 15'h0002);
    check("pd cmd", 32'(n0), 32'(n_cmd));
    check("pd odt_rx", 32'h1, 32'(odt_rx));
    power_down <= 1'b0;
    self_refresh <= 1'b1;
    ctl.send_cmd(1'b0, `DCAD_CODE_ACT, 3'h3, 15'h0003);
    check("sr cmd", 32'(n0), 32'(n_cmd));
    check("sr odt_rx", 32'h0, 32'(odt_rx));
    ctl.cke <= 1'b0;
    repeat (4) @(posedge mclk);
    check("sr cke_rx", 32'h0, 32'(cke_rx));
    ctl.cke <= 1'b1;
    self_refresh <= 1'b0;
    ctl.odt <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // Alternating mask on both strobe edges, then the TDQS setting
  task automatic t_write();
    int n0;
    int n1;
    n0 = n_ok;
    n1 = n_drop;
    wr_active <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      ctl.send_beat(b[0], 8'(8'h3c + b * 8'h41));
      check("wr_data", 32'(8'(8'h3c + b * 8'h41)), 32'(wr_data));
      check("cke in write", 32'h1, 32'(cke_rx));
    end
    check("stored", 32'(n0 + 2), 32'(n_ok));
    check("dropped", 32'(n1 + 2), 32'(n_drop));
    wr_active <= 1'b0;
    ctl.send_beat(1'b0, 8'h77);
    check("idle beat", 32'(n0 + 2), 32'(n_ok));
    ctl.send_cmd(1'b0, `DCAD_CODE_MRS, 3'h1, 15'h0800);
    check("tdqs_mode", 32'h1, 32'(tdqs_mode));
    wr_active <= 1'b1;
    ctl.send_beat(1'b1, 8'h5a);
    check("tdqs beat", 32'(n0 + 3), 32'(n_ok));
    check("tdqs drop", 32'(n1 + 2), 32'(n_drop));
    wr_active <= 1'b0;
  endtask

  // Main sequence after a 3-cycle reset
  initial begin
    rst = 1'b1;
    power_down = 1'b0;
    self_refresh = 1'b0;
    wr_active = 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_mrs();
    t_cmds();
    t_mask_low();
    t_write();
    results();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
